// [core/csc_pkg.sv]
// Package of constants and types for the card socket control block
package csc_pkg;
	// Card type selected in the socket
	typedef enum logic [1:0] {
		CSC_CARD_NONE = 2'b00,
		CSC_CARD_NARROW = 2'b01,
		CSC_CARD_WIDE = 2'b11
	} csc_card_t;
	// Narrow cycle kinds
	typedef enum logic [2:0] {
		CSC_OP_MEM_RD = 3'b000,
		CSC_OP_MEM_WR = 3'b001,
		CSC_OP_ATTR_RD = 3'b010,
		CSC_OP_ATTR_WR = 3'b011,
		CSC_OP_IO_RD = 3'b100,
		CSC_OP_IO_WR = 3'b101,
		CSC_OP_DMA_RD = 3'b110,
		CSC_OP_DMA_WR = 3'b111
	} csc_op_t;
	// Narrow cycle states, Gray along the path
	typedef enum logic [1:0] {
		CSC_ST_IDLE = 2'b00,
		CSC_ST_SETUP = 2'b01,
		CSC_ST_STROBE = 2'b11,
		CSC_ST_HOLD = 2'b10
	} csc_state_t;
	// Decoded card voltage
	typedef enum logic [1:0] {
		CSC_VOLT_5V = 2'b00,
		CSC_VOLT_3V3 = 2'b01,
		CSC_VOLT_XV = 2'b10,
		CSC_VOLT_BAD = 2'b11
	} csc_volt_t;
	// Strobe timing in ns and cycles at 5 ns clock
	localparam int CSC_CLK_NS = 5;
	localparam int CSC_SETUP_NS = 30;
	localparam int CSC_STROBE_NS = 150;
	localparam int CSC_HOLD_NS = 20;
	localparam logic [7:0] CSC_SETUP_CYC =
		8'((CSC_SETUP_NS + CSC_CLK_NS - 1) / CSC_CLK_NS);
	localparam logic [7:0] CSC_STROBE_CYC =
		8'((CSC_STROBE_NS + CSC_CLK_NS - 1) / CSC_CLK_NS);
	localparam logic [7:0] CSC_HOLD_CYC =
		8'((CSC_HOLD_NS + CSC_CLK_NS - 1) / CSC_CLK_NS);
	// Card clock divider reload, one less than the half period in host cycles
	localparam logic [3:0] CSC_CARD_CLOCK_HALF_FAST = 4'h1;
	localparam logic [3:0] CSC_CARD_CLOCK_HALF_SLOW = 4'h8;
	// Reset values
	localparam logic [7:0] CSC_CNT_RST = 8'h00;
endpackage

// [core/csc_sync2.sv]
// Two flip-flop synchroniser for a group of level inputs
`timescale 1ns/10ps
`default_nettype none
module csc_sync2 #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clock,
	input  wire logic         rst,
	// Level in and out
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] meta_q; // First stage, read only by second
	// Two stage capture
	always_ff @(posedge clock) begin
		if (rst) begin
			meta_q <= '1;
			dout <= '1;
		end else begin
			meta_q <= din;
			dout <= meta_q;
		end
	end
endmodule
`default_nettype wire

// [core/csc_host.sv]
// Host side controller for the narrow and wide card socket signals
//
// Behaviour
// - Memory card drives ready low while busy
// - I/O card asserts interrupt request low
// - Wait input stretches the cycle in progress
// - Memory card shows write protect switch
// - Wide port indication only on decoded ports
// - Write protect line doubles as DMA request
// - Wide signals sampled on rising card clock
// - Clock run requests and announces slowdown
// - Drive wide signals during wide reset
// - Wide card resets its own state
`timescale 1ns/10ps
`default_nettype none
module csc_host
	import csc_pkg::*;
(
	// Host clock and reset
	input  wire logic       clock,
	input  wire logic       rst,
	// Socket configuration
	input  wire csc_card_t  card_type,
	input  wire logic       memory_only,
	input  wire logic       card_reset_req,
	input  wire logic       clock_slow_req,
	input  wire logic       clock_stop_req,
	// Narrow cycle request
	input  wire logic       cyc_req,
	input  wire csc_op_t    cyc_op,
	input  wire logic       cyc_last,
	output logic            cyc_ready,
	output logic            cyc_done,
	// Narrow socket outputs, active low
	output logic            attr_sel_n,
	output logic            oe_n,
	output logic            we_n,
	output logic            io_read_strobe_n,
	output logic            io_write_strobe_n,
	// Narrow socket inputs, active low where marked
	input  wire logic       ready_irq_pin,
	input  wire logic       wait_n,
	input  wire logic       wp_pin,
	input  wire logic       volt_sense_a_n,
	input  wire logic       volt_sense_b_n,
	// Decoded narrow status
	output logic            card_ready,
	output logic            card_irq_request,
	output logic            write_protect,
	output logic            wide_port_indication,
	output logic            dma_request,
	output csc_volt_t       card_volt,
	// Shared reset pin
	output logic            reset_pin_o,
	output logic            reset_pin_oe_n,
	// Wide card clock and clock run
	output logic            card_clock,
	input  wire logic       card_clock_run_i,
	output logic            card_clock_run_o,
	output logic            card_clock_run_oe_n,
	output logic            clock_fast_wanted,
	// Wide card link side
	input  wire logic       link_clock,
	output logic            wide_bus_oe_n
);
	// Synchronised pin levels, clock run included
	logic [5:0] pin_s;
	logic       ready_s, wait_s_n, wp_s, vsa_s_n, vsb_s_n;
	logic       run_s;
	csc_sync2 #(.W(6)) u_sync_pins (
		.clock (clock),
		.rst   (rst),
		.din   ({ready_irq_pin, wait_n, wp_pin,
		         volt_sense_a_n, volt_sense_b_n, card_clock_run_i}),
		.dout  (pin_s)
	);
	assign {ready_s, wait_s_n, wp_s, vsa_s_n, vsb_s_n, run_s} = pin_s;

	// Busy line meaning depends on interface mode
	always_ff @(posedge clock) begin
		if (rst) begin
			card_ready <= 1'b0;
			card_irq_request <= 1'b0;
		end else begin
			card_ready <= memory_only & ready_s;
			card_irq_request <= ~memory_only & ~ready_s;
		end
	end

	// Write protect line: switch, wide port or DMA request
	always_ff @(posedge clock) begin
		if (rst) begin
			write_protect <= 1'b0;
			wide_port_indication <= 1'b0;
			dma_request <= 1'b0;
		end else begin
			write_protect <= memory_only & wp_s;
			wide_port_indication <= ~memory_only & ~wp_s;
			dma_request <= ~memory_only & wp_s;
		end
	end

	// Joint voltage sense decode
	always_ff @(posedge clock) begin
		if (rst) begin
			card_volt <= CSC_VOLT_5V;
		end else begin
			case ({vsb_s_n, vsa_s_n})
				2'b11: card_volt <= CSC_VOLT_5V;
				2'b10: card_volt <= CSC_VOLT_3V3;
				2'b01: card_volt <= CSC_VOLT_XV;
				default: card_volt <= CSC_VOLT_BAD;
			endcase
		end
	end

	// Narrow cycle sequencer
	csc_state_t state_q;
	csc_op_t    op_q;
	logic       last_q;
	logic [7:0] cnt_q;
	wire        cnt_end = (cnt_q == 8'h01);
	wire        narrow_ok = (card_type == CSC_CARD_NARROW);
	assign cyc_ready = (state_q == CSC_ST_IDLE) & narrow_ok;
	always_ff @(posedge clock) begin
		if (rst) begin
			state_q <= CSC_ST_IDLE;
			op_q <= CSC_OP_MEM_RD;
			last_q <= 1'b0;
			cnt_q <= CSC_CNT_RST;
			cyc_done <= 1'b0;
		end else begin
			cyc_done <= 1'b0;
			if (cnt_q != CSC_CNT_RST) begin
				cnt_q <= cnt_q - 8'h01;
			end
			case (state_q)
				CSC_ST_IDLE: begin
					if (cyc_req && cyc_ready) begin
						op_q <= cyc_op;
						last_q <= cyc_last;
						cnt_q <= CSC_SETUP_CYC;
						state_q <= CSC_ST_SETUP;
					end
				end
				CSC_ST_SETUP: begin
					if (cnt_end) begin
						cnt_q <= CSC_STROBE_CYC;
						state_q <= CSC_ST_STROBE;
					end
				end
				CSC_ST_STROBE: begin
					// Stretch while card holds wait low
					if (cnt_q <= 8'h01 && wait_s_n) begin
						cnt_q <= CSC_HOLD_CYC;
						state_q <= CSC_ST_HOLD;
					end else if (cnt_end) begin
						cnt_q <= cnt_q;
					end
				end
				CSC_ST_HOLD: begin
					if (cnt_end) begin
						cyc_done <= 1'b1;
						state_q <= CSC_ST_IDLE;
					end
				end
				default: state_q <= CSC_ST_IDLE;
			endcase
		end
	end

	// Socket strobes registered from state and kind
	wire act = (state_q != CSC_ST_IDLE);
	wire stb = (state_q == CSC_ST_STROBE);
	always_ff @(posedge clock) begin
		if (rst) begin
			attr_sel_n <= 1'b1;
			oe_n <= 1'b1;
			we_n <= 1'b1;
			io_read_strobe_n <= 1'b1;
			io_write_strobe_n <= 1'b1;
		end else begin
			// Common memory keeps select high
			attr_sel_n <= ~(act & (op_q[2] | op_q[1]));
			oe_n <= ~(stb & ((op_q == CSC_OP_MEM_RD) |
				(op_q == CSC_OP_ATTR_RD) |
				((op_q == CSC_OP_DMA_WR) & last_q)));
			we_n <= ~(stb & ((op_q == CSC_OP_MEM_WR) |
				(op_q == CSC_OP_ATTR_WR) |
				((op_q == CSC_OP_DMA_RD) & last_q)));
			io_read_strobe_n <= ~(stb & ((op_q == CSC_OP_IO_RD) |
				(op_q == CSC_OP_DMA_WR)));
			io_write_strobe_n <= ~(stb & ((op_q == CSC_OP_IO_WR) |
				(op_q == CSC_OP_DMA_RD)));
		end
	end

	// Card clock divider, stopped clock held low
	logic [3:0] div_q;
	logic       run_fast_q;
	// Stop and slow only while the card does not ask for speed
	wire        card_clock_hold = clock_stop_req & run_s;
	wire        card_clock_rise = ~card_clock_hold & (div_q == 4'h0) & ~card_clock;
	always_ff @(posedge clock) begin
		if (rst) begin
			div_q <= 4'h0;
			card_clock <= 1'b0;
		end else if (card_clock_hold) begin
			div_q <= 4'h0;
			card_clock <= 1'b0;
		end else if (div_q == 4'h0) begin
			div_q <= (clock_slow_req && run_s) ?
				CSC_CARD_CLOCK_HALF_SLOW : CSC_CARD_CLOCK_HALF_FAST;
			card_clock <= ~card_clock;
		end else begin
			div_q <= div_q - 4'h1;
		end
	end

	// Clock run: announce slowdown, hear card requests
	always_ff @(posedge clock) begin
		if (rst) begin
			run_fast_q <= 1'b0;
			card_clock_run_o <= 1'b1;
			card_clock_run_oe_n <= 1'b1;
			clock_fast_wanted <= 1'b0;
		end else begin
			run_fast_q <= clock_slow_req | clock_stop_req;
			card_clock_run_o <= 1'b1;
			card_clock_run_oe_n <= ~((clock_slow_req | clock_stop_req)
				& ~run_fast_q);
			clock_fast_wanted <= ~run_s;
		end
	end

	// Wide reset: async assert, release on link clock
	wire wide_rst_req = card_reset_req | rst |
		(card_type != CSC_CARD_WIDE);
	logic wide_rel_m_q, wide_rel_q;
	always_ff @(posedge link_clock or posedge wide_rst_req) begin
		if (wide_rst_req) begin
			wide_rel_m_q <= 1'b0;
			wide_rel_q <= 1'b0;
		end else begin
			wide_rel_m_q <= 1'b1;
			wide_rel_q <= wide_rel_m_q;
		end
	end
	// Host drives wide bus levels while in reset
	assign wide_bus_oe_n = wide_rel_q;

	// Wide release crossed into the host clock by two flops
	logic rel_m_q, rel_s_q;
	always_ff @(posedge clock) begin
		if (rst) begin
			rel_m_q <= 1'b0;
			rel_s_q <= 1'b0;
		end else begin
			rel_m_q <= wide_rel_q;
			rel_s_q <= rel_m_q;
		end
	end

	// Shared reset pin: narrow high active, wide low active
	// Wide release waits for a card clock rise, so a stopped
	// card clock keeps an unreleased wide card in reset
	always_ff @(posedge clock) begin
		if (rst) begin
			reset_pin_o <= 1'b1;
			reset_pin_oe_n <= 1'b1;
		end else begin
			reset_pin_oe_n <= (card_type == CSC_CARD_NONE);
			if (card_type != CSC_CARD_WIDE) begin
				reset_pin_o <= card_reset_req;
			end else if (!rel_s_q) begin
				reset_pin_o <= 1'b0;
			end else if (card_clock_rise) begin
				reset_pin_o <= 1'b1;
			end
		end
	end

	// Wait stretch: strobe stays while wait low
	property p_wait_hold;
		@(posedge clock) disable iff (rst)
		(stb && !wait_s_n) |=> (state_q == CSC_ST_STROBE);
	endproperty
	a_wait_hold: assert property (p_wait_hold)
		else $error("cycle left strobe while wait held");
	property p_common_sel;
		@(posedge clock) disable iff (rst)
		(act && op_q == CSC_OP_MEM_RD) |=> attr_sel_n;
	endproperty
	a_common_sel: assert property (p_common_sel)
		else $error("attribute select low on common read");
	property p_stop_low;
		@(posedge clock) disable iff (rst)
		(clock_stop_req && run_s)[*2] |-> !card_clock;
	endproperty
	a_stop_low: assert property (p_stop_low)
		else $error("stopped card clock not low");
	property p_ready_mode;
		@(posedge clock) disable iff (rst)
		!$past(memory_only) |-> !card_ready;
	endproperty
	a_ready_mode: assert property (p_ready_mode)
		else $error("ready reported outside memory mode");
	property p_tc_we;
		@(posedge clock) disable iff (rst)
		(stb && op_q == CSC_OP_DMA_RD && last_q) |=> !we_n;
	endproperty
	a_tc_we: assert property (p_tc_we)
		else $error("terminal count missing on write enable");
	property p_tc_oe;
		@(posedge clock) disable iff (rst)
		(stb && op_q == CSC_OP_DMA_WR && last_q) |=> !oe_n && !io_read_strobe_n;
	endproperty
	a_tc_oe: assert property (p_tc_oe)
		else $error("terminal count missing on output enable");
	property p_dma_acknowledge;
		@(posedge clock) disable iff (rst)
		(act && op_q == CSC_OP_DMA_RD) |=> !attr_sel_n;
	endproperty
	a_dma_acknowledge: assert property (p_dma_acknowledge)
		else $error("dma acknowledge missing");
	property p_wide_rst;
		@(posedge clock) disable iff (rst)
		(card_type == CSC_CARD_WIDE && !rel_s_q) |=> !reset_pin_o;
	endproperty
	a_wide_rst: assert property (p_wide_rst)
		else $error("shared reset polarity wrong for wide card");
	property p_rel_sync;
		@(posedge clock) disable iff (rst)
		($rose(reset_pin_o) && $past(card_type) == CSC_CARD_WIDE)
			|-> $rose(card_clock);
	endproperty
	a_rel_sync: assert property (p_rel_sync)
		else $error("wide reset released off the card clock rise");
endmodule
`default_nettype wire

// [dv/csc_card_model.sv]
// Behavioural model of a card plugged into the socket
`timescale 1ns/10ps
`default_nettype none
module csc_card_model (
	// Host clock
	input  wire logic       clock,
	// Scenario controls
	input  wire logic       busy,
	input  wire logic       wp_sw,
	input  wire logic       fast,
	input  wire logic [1:0] vs,
	input  wire logic [7:0] stretch,
	// Socket pins from the host
	input  wire logic       oe_n,
	input  wire logic       we_n,
	input  wire logic       card_clock_run_o,
	input  wire logic       card_clock_run_oe_n,
	input  wire logic       reset_pin_o,
	// Socket pins to the host
	output logic            ready_irq_pin,
	output logic            wait_n,
	output logic            wp_pin,
	output logic            volt_sense_a_n,
	output logic            volt_sense_b_n,
	output logic            card_clock_run_i
);
	logic [7:0] cnt_q; // Wait cycles still owed
	// Busy or pending service pulls the shared line low
	assign ready_irq_pin = ~busy;
	// Switch, wide port and request share one line
	assign wp_pin = wp_sw;
	// Sense pins straight from the card coding
	assign {volt_sense_b_n, volt_sense_a_n} = vs;
	// Wired line with pull-up; card pulls low for speed, but
	// floats it and forgets the request while held in reset
	assign card_clock_run_i = !card_clock_run_oe_n ?
		card_clock_run_o : !(fast && reset_pin_o);
	// Wait released by the pull-up outside strobes
	assign wait_n = (oe_n & we_n) | (cnt_q == 8'h00);
	// Count down the stretch while a strobe is low
	always_ff @(posedge clock) begin
		if (oe_n && we_n) begin
			cnt_q <= stretch;
		end else if (cnt_q != 8'h00) begin
			cnt_q <= cnt_q - 8'h01;
		end
	end
endmodule
`default_nettype wire

// [dv/tb_card_socket_control_signalling.sv]
// Self-checking bench for the card socket controller
`timescale 1ns/10ps
`default_nettype none
module tb_card_socket_control_signalling
	import csc_pkg::*;
;
	// Host side stimulus
	logic       clock, link_clock, rst, memory_only, card_reset_req;
	logic       clock_slow_req, clock_stop_req, cyc_req, cyc_last;
	csc_card_t  card_type;
	csc_op_t    cyc_op;
	// Design outputs and socket pins
	logic       cyc_ready, cyc_done, attr_sel_n, oe_n, we_n;
	logic       io_read_strobe_n, io_write_strobe_n, ready_irq_pin;
	logic       wait_n, wp_pin, volt_sense_a_n, volt_sense_b_n;
	logic       card_ready, card_irq_request, write_protect;
	logic       wide_port_indication, dma_request, reset_pin_o;
	logic       reset_pin_oe_n, card_clock, card_clock_run_i;
	logic       card_clock_run_o, card_clock_run_oe_n;
	logic       clock_fast_wanted, wide_bus_oe_n;
	csc_volt_t  card_volt;
	// Card model controls
	logic       busy, wp_sw, fast;
	logic [1:0] vs;
	logic [7:0] stretch;
	// Bookkeeping
	int         error_cnt, samples_checked, ticks;

	csc_host uut (.clock, .rst, .card_type, .memory_only,
		.card_reset_req, .clock_slow_req, .clock_stop_req, .cyc_req,
		.cyc_op, .cyc_last, .cyc_ready, .cyc_done, .attr_sel_n, .oe_n,
		.we_n, .io_read_strobe_n, .io_write_strobe_n, .ready_irq_pin,
		.wait_n, .wp_pin, .volt_sense_a_n, .volt_sense_b_n, .card_ready,
		.card_irq_request, .write_protect, .wide_port_indication,
		.dma_request, .card_volt, .reset_pin_o, .reset_pin_oe_n,
		.card_clock, .card_clock_run_i, .card_clock_run_o,
		.card_clock_run_oe_n, .clock_fast_wanted, .link_clock,
		.wide_bus_oe_n);
	csc_card_model card (.clock, .busy, .wp_sw, .fast, .vs, .stretch,
		.oe_n, .we_n, .card_clock_run_o, .card_clock_run_oe_n, .reset_pin_o,
		.ready_irq_pin, .wait_n, .wp_pin, .volt_sense_a_n,
		.volt_sense_b_n, .card_clock_run_i);

	// Host clock, 5 ns
	always #2.5 clock = ~clock;
	// Link clock, 30 ns, offset from the host clock
	initial begin
		link_clock = 1'b0;
		#3.3;
		forever #15 link_clock = ~link_clock;
	end
	// Cut a hang short
	always @(posedge clock) begin
		ticks++;
		if (ticks == 30000) begin
			error_cnt++;
			summarize();
		end
	end

	// Compare one result and count it
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Print counts and the verdict, then stop
	task automatic summarize;
		$display("checks=%0d errors=%0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Step to a falling edge k times
	task automatic nc(input int k);
		repeat (k) @(negedge clock);
	endtask
	// One narrow cycle; collects strobes seen low and length
	task automatic cyc(input csc_op_t op, input logic last,
			output logic [4:0] seen, output int len);
		seen = 5'h00;
		len = 0;
		while (cyc_ready !== 1'b1 && len < 200) begin
			nc(1);
			len++;
		end
		len = 0;
		cyc_op = op;
		cyc_last = last;
		cyc_req = 1'b1;
		nc(1);
		cyc_req = 1'b0;
		while (cyc_done !== 1'b1 && len < 400) begin
			@(posedge clock);
			#1;
			seen |= ~{attr_sel_n, oe_n, we_n, io_read_strobe_n,
				io_write_strobe_n};
			len++;
		end
		chk(8'(cyc_done), 8'h01);
		nc(1);
	endtask
	// Every cycle kind, the DMA kinds with and without terminal count
	task automatic t_cycles;
		logic [4:0] ex [10] = '{5'h08, 5'h04, 5'h18, 5'h14, 5'h12,
			5'h11, 5'h15, 5'h1a, 5'h11, 5'h12};
		logic [4:0] s;
		int l;
		for (int i = 0; i < 10; i++) begin
			cyc(csc_op_t'((i < 8) ? i[2:0] : i[2:0] + 3'h6),
				i == 6 || i == 7, s, l);
			chk(8'(s), 8'(ex[i]));
		end
	endtask
	// Card wait must stretch the cycle
	task automatic t_wait;
		logic [4:0] s;
		int l0, l1;
		cyc(CSC_OP_MEM_RD, 1'b0, s, l0);
		stretch = 8'h50;
		cyc(CSC_OP_MEM_RD, 1'b0, s, l1);
		stretch = 8'h00;
		chk(8'(l1 - l0 >= 45), 8'h01);
	endtask
	// Sense decode and shared status lines
	task automatic t_status;
		logic [1:0] e;
		logic [7:0] g, x;
		for (int i = 0; i < 4; i++) begin
			vs = i[1:0];
			e = ~vs;
			nc(5);
			chk(8'(card_volt), 8'(e));
		end
		for (int m = 0; m < 4; m++) begin
			memory_only = m[1];
			busy = m[0];
			wp_sw = m[0];
			nc(5);
			g = {3'h0, card_ready, write_protect, card_irq_request,
				dma_request, wide_port_indication};
			x = m[1] ? {3'h0, ~busy, busy, 3'h0} : {5'h00, busy, busy, ~busy};
			chk(g, x);
		end
	endtask
	// Shared reset pin for narrow then wide cards
	task automatic t_reset;
		card_reset_req = 1'b1;
		nc(3);
		chk(8'({reset_pin_oe_n, reset_pin_o}), 8'h01);
		card_reset_req = 1'b0;
		nc(3);
		chk(8'({reset_pin_oe_n, reset_pin_o}), 8'h00);
		card_type = CSC_CARD_WIDE;
		card_reset_req = 1'b1;
		nc(3);
		chk(8'({reset_pin_oe_n, reset_pin_o, wide_bus_oe_n}), 8'h00);
		card_reset_req = 1'b0;
		nc(2);
		chk(8'({reset_pin_o, wide_bus_oe_n}), 8'h00);
		nc(40);
		chk(8'({reset_pin_o, wide_bus_oe_n}), 8'h03);
	endtask
	// Count card clock rising edges and any announcement
	task automatic edges(input int k, output int n, output logic ann);
		logic p;
		n = 0;
		ann = 1'b0;
		p = card_clock;
		repeat (k) begin
			@(posedge clock);
			#1;
			if (card_clock && !p)
				n++;
			p = card_clock;
			if (!card_clock_run_oe_n && card_clock_run_o)
				ann = 1'b1;
		end
		nc(1);
	endtask
	// Card clock speeds, stop and clock run
	task automatic t_clock;
		int n, pf;
		logic a;
		pf = 2 * (int'(CSC_CARD_CLOCK_HALF_FAST) + 1);
		chk(8'(clock_fast_wanted), 8'h00);
		edges(40, n, a);
		chk(8'(n >= 40 / pf - 1 && n <= 40 / pf + 1), 8'h01);
		clock_slow_req = 1'b1;
		edges(8, n, a);
		chk(8'(a), 8'h01);
		edges(64, n, a);
		chk(8'(n >= 3 && n <= 5), 8'h01);
		clock_stop_req = 1'b1;
		nc(40);
		edges(40, n, a);
		chk(8'({n == 0, card_clock}), 8'h02);
		fast = 1'b1;
		nc(6);
		chk(8'(clock_fast_wanted), 8'h01);
		card_reset_req = 1'b1;
		nc(10);
		chk(8'(clock_fast_wanted), 8'h00);
		{fast, card_reset_req} = 2'b00;
	endtask

	// Main sequence
	initial begin
		clock = 1'b0;
		rst = 1'b1;
		{memory_only, card_reset_req, clock_slow_req} = 3'h0;
		{clock_stop_req, cyc_req, cyc_last} = 3'h0;
		{busy, wp_sw, fast, vs, stretch} = 13'h0300;
		card_type = CSC_CARD_NARROW;
		cyc_op = CSC_OP_MEM_RD;
		{error_cnt, samples_checked, ticks} = '0;
		nc(3);
		rst = 1'b0;
		nc(4);
		chk(8'({attr_sel_n, oe_n, we_n, io_read_strobe_n}), 8'h0f);
		t_cycles();
		t_wait();
		t_status();
		t_reset();
		t_clock();
		summarize();
	end
endmodule
`default_nettype wire
